// ===== logic/motion_cfg.svh
// register map, field positions, reset values and timing counts
// assumes a 100 MHz CLK and an 8-bit register port
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

`define GYRO_CFG_ADDR      8'h1B
`define ACCEL_CFG_ADDR     8'h1C
`define ACCEL_CFG2_ADDR    8'h1D

`define GYRO_CFG_RESET     8'h00
`define ACCEL_CFG_RESET    8'h00
`define ACCEL_CFG2_RESET   8'h00
`define GYRO_CFG_MASK      8'hFB
`define ACCEL_CFG_MASK     8'hF8
`define ACCEL_CFG2_MASK    8'h3F

`define SELFTEST_HI        7
`define SELFTEST_LO        5
`define RANGE_HI           4
`define RANGE_LO           3
`define GBYPASS_HI         1
`define GBYPASS_LO         0
`define AVG_HI             5
`define AVG_LO             4
`define ABYPASS_BIT        3
`define ALPF_HI            2
`define ALPF_LO            0

`define GYRO_BASE_DPS      12'h0FA
`define ACCEL_BASE_G       5'h02
`define GYRO_WIDE_KHZ      6'h20
`define GYRO_MID_KHZ       6'h08
`define BASE_KHZ           6'h01
`define ACCEL_WIDE_KHZ     6'h04
`define AVG_BASE           6'h04
`define ALPF_TOP           3'h7

`define CLK_PERIOD_NS      10
`define INTERNAL_PERIOD_NS 1000000
`define TON_1X_NS          1084000
`define TON_4X_NS          1840000
`define TON_8X_NS          2840000
`define TON_16X_NS         4840000
`define TON_32X_NS         8840000
`define COUNT_W            20

`endif

// ===== logic/motion_cfg_pkg.sv
// types shared by the motion configuration bank and its sample pacer
// constants live in motion_cfg.svh
package motion_cfg_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [1:0]  range_code_t;
    typedef logic [2:0]  axis_bits_t;
    typedef logic [5:0]  rate_khz_t;
    typedef enum logic { DUTY_IDLE, DUTY_ON } duty_state_t;
endpackage

// ===== logic/motion_range_filter_config.sv
// range, self-test, filter and low-power averaging configuration bank
// register port is synchronous to CLK; divider and gyro filter setting
// come from neighbouring registers as plain inputs
`timescale 1ns/100ps
`include "motion_cfg.svh"
module motion_range_filter_config #(
    parameter int TICK_CYCLES = `INTERNAL_PERIOD_NS / `CLK_PERIOD_NS,
    parameter int TON_1X      = `TON_1X_NS / `CLK_PERIOD_NS,
    parameter int TON_4X      = `TON_4X_NS / `CLK_PERIOD_NS,
    parameter int TON_8X      = `TON_8X_NS / `CLK_PERIOD_NS,
    parameter int TON_16X     = `TON_16X_NS / `CLK_PERIOD_NS,
    parameter int TON_32X     = `TON_32X_NS / `CLK_PERIOD_NS
) (
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire motion_cfg_pkg::reg_byte_t   REG_ADDR,
    input  wire motion_cfg_pkg::reg_byte_t   REG_WDATA,
    input  wire logic                        REG_WRITE,
    input  wire logic                        REG_READ,
    output motion_cfg_pkg::reg_byte_t        REG_RDATA,
    input  wire logic [2:0]                  GYRO_LOWPASS_SETTING,
    input  wire motion_cfg_pkg::reg_byte_t   SAMPLE_RATE_DIVIDER,
    input  wire logic                        ACCEL_LOWPOWER_MODE,
    output motion_cfg_pkg::axis_bits_t       GYRO_SELFTEST,
    output motion_cfg_pkg::range_code_t      GYRO_RANGE_SELECT,
    output logic [11:0]                      GYRO_FULL_SCALE_DPS,
    output logic                             GYRO_FILTER_ON,
    output logic                             GYRO_NARROW_BYPASS,
    output motion_cfg_pkg::rate_khz_t        GYRO_RATE_KHZ,
    output motion_cfg_pkg::axis_bits_t       ACCEL_SELFTEST,
    output motion_cfg_pkg::range_code_t      ACCEL_RANGE_SELECT,
    output logic [4:0]                       ACCEL_FULL_SCALE_G,
    output logic                             ACCEL_FILTER_ON,
    output logic [2:0]                       ACCEL_LOWPASS_SETTING,
    output motion_cfg_pkg::rate_khz_t        ACCEL_RATE_KHZ,
    output motion_cfg_pkg::rate_khz_t        ACCEL_AVERAGES,
    output logic                             ACCEL_POWER_ON,
    output logic                             SAMPLE_STROBE
);
    import motion_cfg_pkg::*;
    function automatic logic [2:0] reg_select(input reg_byte_t addr);
        reg_select = {addr == `ACCEL_CFG2_ADDR, addr == `ACCEL_CFG_ADDR,
                      addr == `GYRO_CFG_ADDR};
    endfunction
    // setting 7 with averaging is what the on-times assume
    function automatic logic [`COUNT_W-1:0] ton_select(input logic bypass,
                                                       input logic [1:0] avg);
        unique case ({bypass, avg})
            3'b000:  ton_select = `COUNT_W'(TON_4X);
            3'b001:  ton_select = `COUNT_W'(TON_8X);
            3'b010:  ton_select = `COUNT_W'(TON_16X);
            3'b011:  ton_select = `COUNT_W'(TON_32X);
            default: ton_select = `COUNT_W'(TON_1X);
        endcase
    endfunction

    pacer_if pif ();
    sample_pacer #(.TICK_CYCLES(TICK_CYCLES)) u_pacer (
        .clk   (CLK),
        .reset (RESET),
        .pif   (pif)
    );
    reg_byte_t           gyro_cfg_reg,  gyro_cfg_next;
    reg_byte_t           accel_cfg_reg, accel_cfg_next;
    reg_byte_t           accel_cfg2_reg, accel_cfg2_next;
    reg_byte_t           rdata_reg,     rdata_next;
    logic [2:0]          wsel, rsel;
    // register bank; reserved bits never stored
    always_comb
    begin
        wsel            = reg_select(REG_ADDR) & {3{REG_WRITE}};
        rsel            = reg_select(REG_ADDR);
        gyro_cfg_next   = gyro_cfg_reg;
        accel_cfg_next  = accel_cfg_reg;
        accel_cfg2_next = accel_cfg2_reg;
        if (wsel[0])
            gyro_cfg_next = REG_WDATA & `GYRO_CFG_MASK;
        if (wsel[1])
            accel_cfg_next = REG_WDATA & `ACCEL_CFG_MASK;
        if (wsel[2])
            accel_cfg2_next = REG_WDATA & `ACCEL_CFG2_MASK;
        rdata_next = REG_RDATA;
        if (REG_READ)
            // unmapped addresses read zero
            rdata_next = ({8{rsel[0]}} & gyro_cfg_reg)
                       | ({8{rsel[1]}} & accel_cfg_reg)
                       | ({8{rsel[2]}} & accel_cfg2_reg);
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            gyro_cfg_reg   <= `GYRO_CFG_RESET;
            accel_cfg_reg  <= `ACCEL_CFG_RESET;
            accel_cfg2_reg <= `ACCEL_CFG2_RESET;
            rdata_reg      <= 8'h00;
        end
        else
        begin
            gyro_cfg_reg   <= gyro_cfg_next;
            accel_cfg_reg  <= accel_cfg_next;
            accel_cfg2_reg <= accel_cfg2_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    // decoded from next values: change on the edge that stores the byte
    logic [1:0]  g_byp, g_rng, a_rng, a_avg;
    logic        a_byp;
    logic [2:0]  g_st, a_st, a_lpf;
    logic [11:0] g_dps_next;
    rate_khz_t   g_rate_next, a_rate_next, a_avgs_next;
    always_comb
    begin
        g_st  = gyro_cfg_next[`SELFTEST_HI:`SELFTEST_LO];
        a_st  = accel_cfg_next[`SELFTEST_HI:`SELFTEST_LO];
        a_lpf = accel_cfg2_next[`ALPF_HI:`ALPF_LO];
        g_byp = gyro_cfg_next[`GBYPASS_HI:`GBYPASS_LO];
        g_rng = gyro_cfg_next[`RANGE_HI:`RANGE_LO];
        a_rng = accel_cfg_next[`RANGE_HI:`RANGE_LO];
        a_byp = accel_cfg2_next[`ABYPASS_BIT];
        a_avg = accel_cfg2_next[`AVG_HI:`AVG_LO];
        g_dps_next = `GYRO_BASE_DPS << g_rng;
        if (g_byp != 2'b00)
            g_rate_next = `GYRO_WIDE_KHZ;
        else if (GYRO_LOWPASS_SETTING == 3'h0
                 || GYRO_LOWPASS_SETTING == `ALPF_TOP)
            g_rate_next = `GYRO_MID_KHZ;
        else
            g_rate_next = `BASE_KHZ;
        a_rate_next = a_byp ? `ACCEL_WIDE_KHZ : `BASE_KHZ;
        a_avgs_next = a_byp ? `BASE_KHZ : `AVG_BASE << a_avg;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            GYRO_SELFTEST         <= 3'h0;
            GYRO_RANGE_SELECT     <= 2'h0;
            GYRO_FULL_SCALE_DPS   <= `GYRO_BASE_DPS;
            GYRO_FILTER_ON        <= 1'b1;
            GYRO_NARROW_BYPASS    <= 1'b0;
            GYRO_RATE_KHZ         <= `BASE_KHZ;
            ACCEL_SELFTEST        <= 3'h0;
            ACCEL_RANGE_SELECT    <= 2'h0;
            ACCEL_FULL_SCALE_G    <= `ACCEL_BASE_G;
            ACCEL_FILTER_ON       <= 1'b1;
            ACCEL_LOWPASS_SETTING <= 3'h0;
            ACCEL_RATE_KHZ        <= `BASE_KHZ;
            ACCEL_AVERAGES        <= `AVG_BASE;
        end
        else
        begin
            GYRO_SELFTEST         <= g_st;
            GYRO_RANGE_SELECT     <= g_rng;
            GYRO_FULL_SCALE_DPS   <= g_dps_next;
            GYRO_FILTER_ON        <= g_byp == 2'b00;
            GYRO_NARROW_BYPASS    <= g_byp == 2'b10;
            GYRO_RATE_KHZ         <= g_rate_next;
            ACCEL_SELFTEST        <= a_st;
            ACCEL_RANGE_SELECT    <= a_rng;
            ACCEL_FULL_SCALE_G    <= `ACCEL_BASE_G << a_rng;
            ACCEL_FILTER_ON       <= !a_byp;
            ACCEL_LOWPASS_SETTING <= a_lpf;
            ACCEL_RATE_KHZ        <= a_rate_next;
            ACCEL_AVERAGES        <= a_avgs_next;
        end
    end
    // divider only counts in the filtered gyro settings 1 to 6
    assign pif.divider    = SAMPLE_RATE_DIVIDER;
    assign pif.div_enable = gyro_cfg_reg[`GBYPASS_HI:`GBYPASS_LO] == 2'b00
                            && GYRO_LOWPASS_SETTING != 3'h0
                            && GYRO_LOWPASS_SETTING != `ALPF_TOP;
    assign SAMPLE_STROBE  = pif.strobe;

    // low-power duty cycle: wake on a sample strobe that arrives while idle, for the on-time
    duty_state_t         duty_reg, duty_next;
    logic [`COUNT_W-1:0] on_cnt_reg, on_cnt_next;
    logic                power_next;

    always_comb
    begin
        duty_next   = duty_reg;
        on_cnt_next = on_cnt_reg;
        unique case (duty_reg)
            DUTY_IDLE:
                if (ACCEL_LOWPOWER_MODE && pif.strobe)
                begin
                    duty_next   = DUTY_ON;
                    on_cnt_next = ton_select(accel_cfg2_reg[`ABYPASS_BIT],
                        accel_cfg2_reg[`AVG_HI:`AVG_LO]) - `COUNT_W'(1);
                end
            DUTY_ON:
                if (on_cnt_reg == '0)
                    duty_next = DUTY_IDLE;
                else
                    on_cnt_next = on_cnt_reg - `COUNT_W'(1);
        endcase
        // leaving low-power mode powers the sensor straight away
        if (!ACCEL_LOWPOWER_MODE)
            duty_next = DUTY_IDLE;
        power_next = !ACCEL_LOWPOWER_MODE || duty_next == DUTY_ON;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            duty_reg       <= DUTY_IDLE;
            on_cnt_reg     <= '0;
            ACCEL_POWER_ON <= 1'b1;
        end
        else
        begin
            duty_reg       <= duty_next;
            on_cnt_reg     <= on_cnt_next;
            ACCEL_POWER_ON <= power_next;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_gyro_range;
        REG_WRITE && REG_ADDR == `GYRO_CFG_ADDR |=>
            GYRO_RANGE_SELECT == $past(REG_WDATA[4:3])
            && GYRO_FULL_SCALE_DPS == (12'h0FA << $past(REG_WDATA[4:3]));
    endproperty
    a_gyro_range: assert property (p_gyro_range)
        else $error("gyro range did not follow write");
    property p_gyro_filter;
        GYRO_FILTER_ON == (gyro_cfg_reg[1:0] == 2'b00);
    endproperty
    a_gyro_filter: assert property (p_gyro_filter)
        else $error("gyro filter state disagrees with bypass");
    property p_gyro_wide;
        gyro_cfg_reg[1:0] != 2'b00 |-> GYRO_RATE_KHZ == 6'h20
            && !pif.div_enable;
    endproperty
    a_gyro_wide: assert property (p_gyro_wide)
        else $error("bypassed gyro not at 32 kHz");
    property p_accel_range;
        REG_WRITE && REG_ADDR == `ACCEL_CFG_ADDR |=>
            ACCEL_FULL_SCALE_G == (5'h02 << $past(REG_WDATA[4:3]));
    endproperty
    a_accel_range: assert property (p_accel_range)
        else $error("accel range did not follow write");
    property p_averages;
        !accel_cfg2_reg[3] |-> ACCEL_AVERAGES ==
            (6'h04 << accel_cfg2_reg[5:4]);
    endproperty
    a_averages: assert property (p_averages)
        else $error("averaging count wrong");
    property p_accel_rate;
        ACCEL_RATE_KHZ == (accel_cfg2_reg[3] ? 6'h04 : 6'h01)
            && ACCEL_FILTER_ON == !accel_cfg2_reg[3];
    endproperty
    a_accel_rate: assert property (p_accel_rate)
        else $error("accel rate or filter state wrong");
    property p_selftest;
        REG_WRITE && REG_ADDR == `ACCEL_CFG_ADDR |=>
            ACCEL_SELFTEST == $past(REG_WDATA[7:5]);
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("accel self-test did not follow write");
    property p_reserved;
        REG_READ && REG_ADDR == `GYRO_CFG_ADDR |=> REG_RDATA[2] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved gyro bit read nonzero");
    property p_wake;
        ACCEL_LOWPOWER_MODE && duty_reg == DUTY_IDLE && pif.strobe
            ##1 ACCEL_LOWPOWER_MODE |-> ACCEL_POWER_ON;
    endproperty
    a_wake: assert property (p_wake)
        else $error("low-power accel not woken by sample");
    c_lowpower_cycle: cover property (duty_reg == DUTY_ON
        ##1 duty_reg == DUTY_IDLE);
    c_gyro_bypass: cover property (GYRO_NARROW_BYPASS);
    c_accel_write: cover property (REG_WRITE && REG_ADDR == `ACCEL_CFG2_ADDR);
endmodule

// ===== logic/pacer_if.sv
// divider setting and sample strobe between the bank and its pacer
// single clock domain
`timescale 1ns/100ps
interface pacer_if;
    logic [7:0] divider;
    logic       div_enable;
    logic       strobe;
    modport pacer  (input divider, input div_enable, output strobe);
    modport client (output divider, output div_enable, input strobe);
endinterface

// ===== logic/sample_pacer.sv
// 1 kHz internal tick, divided by one plus the divider when enabled
// tick length is a parameter so simulation can shorten it
`timescale 1ns/100ps
`include "motion_cfg.svh"
module sample_pacer #(
    parameter int TICK_CYCLES = `INTERNAL_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        reset,
    pacer_if.pacer           pif
);
    import motion_cfg_pkg::*;

    logic [`COUNT_W-1:0] tick_cnt_reg;
    logic [`COUNT_W-1:0] tick_cnt_next;
    logic [7:0]          div_cnt_reg;
    logic [7:0]          div_cnt_next;
    logic                strobe_reg;
    logic                strobe_next;
    logic                tick;

    always_comb
    begin
        tick          = tick_cnt_reg == `COUNT_W'(TICK_CYCLES - 1);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + `COUNT_W'(1);
        div_cnt_next  = div_cnt_reg;
        strobe_next   = 1'b0;
        if (tick)
        begin
            // >= so a divider lowered mid-count still ends the period
            if (!pif.div_enable || div_cnt_reg >= pif.divider)
            begin
                div_cnt_next = '0;
                strobe_next  = 1'b1;
            end
            else
            begin
                div_cnt_next = div_cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_cnt_reg <= '0;
            div_cnt_reg  <= '0;
            strobe_reg   <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            div_cnt_reg  <= div_cnt_next;
            strobe_reg   <= strobe_next;
        end
    end

    assign pif.strobe = strobe_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_undivided;
        tick && !pif.div_enable |=> pif.strobe;
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("tick without divider gave no strobe");

    // a tick short of the divider count must not strobe
    property p_divided_gap;
        tick && pif.div_enable && div_cnt_reg < pif.divider
            |=> !pif.strobe;
    endproperty
    a_divided_gap: assert property (p_divided_gap)
        else $error("divided tick strobed early");

    c_divided: cover property (pif.div_enable && pif.strobe);
endmodule

// ===== tb/host_model.sv
// host model: drives the register port and the neighbouring register levels
// assumes the bench calls its tasks after a falling edge of clk
`timescale 1ns/100ps
module host_model (
    input  wire logic                        clk,
    output motion_cfg_pkg::reg_byte_t        reg_addr,
    output motion_cfg_pkg::reg_byte_t        reg_wdata,
    output logic                             reg_write,
    output logic                             reg_read,
    input  wire motion_cfg_pkg::reg_byte_t   reg_rdata,
    output logic [2:0]                       gyro_setting,
    output motion_cfg_pkg::reg_byte_t        divider,
    output logic                             lowpower
);
    import motion_cfg_pkg::*;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        gyro_setting = 3'h0;
        divider = 8'h00;
        lowpower = 1'b0;
    end
    // released lines show the inverse, so a stale value never passes
    task automatic write_reg(input reg_byte_t a, input reg_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic read_reg(input reg_byte_t a, output reg_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
    // single sample uses bypass; averaging wants bypass clear, setting 7
    task automatic set_lowpower(input logic [1:0] avg, input logic single);
        if (single)
            write_reg(8'h1D, {2'b00, avg, 1'b1, 3'h0});
        else
            write_reg(8'h1D, {2'b00, avg, 1'b0, 3'h7});
    endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the motion configuration bank
// host_model drives every input except CLK and RESET
`timescale 1ns/100ps
`include "motion_cfg.svh"
module tb_top;
    import motion_cfg_pkg::*;
    localparam int TICK = 4;
    localparam int TON1 = 3;
    localparam int TONS [4] = '{5, 7, 9, 11};
    logic        clk;
    logic        reset;
    reg_byte_t   addr;
    reg_byte_t   wdata;
    reg_byte_t   rdata;
    reg_byte_t   div;
    reg_byte_t   d;
    logic        wr;
    logic        rd;
    logic        lp;
    logic [2:0]  gset;
    axis_bits_t  gst;
    axis_bits_t  ast;
    range_code_t grs;
    range_code_t ars;
    logic [11:0] dps;
    logic [4:0]  gval;
    logic [2:0]  alpf;
    logic        gfon;
    logic        gnar;
    logic        afon;
    logic        pwr;
    logic        stb;
    rate_khz_t   grate;
    rate_khz_t   arate;
    rate_khz_t   avgs;
    int          errors;
    int          n_tests;
    int          cycles;
    int          n;

    host_model host_u (.clk(clk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
        .gyro_setting(gset), .divider(div), .lowpower(lp));

    motion_range_filter_config #(.TICK_CYCLES(TICK), .TON_1X(TON1),
        .TON_4X(TONS[0]), .TON_8X(TONS[1]), .TON_16X(TONS[2]),
        .TON_32X(TONS[3])) dut_u (
        .CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata),
        .GYRO_LOWPASS_SETTING(gset), .SAMPLE_RATE_DIVIDER(div),
        .ACCEL_LOWPOWER_MODE(lp), .GYRO_SELFTEST(gst),
        .GYRO_RANGE_SELECT(grs), .GYRO_FULL_SCALE_DPS(dps),
        .GYRO_FILTER_ON(gfon), .GYRO_NARROW_BYPASS(gnar),
        .GYRO_RATE_KHZ(grate), .ACCEL_SELFTEST(ast),
        .ACCEL_RANGE_SELECT(ars), .ACCEL_FULL_SCALE_G(gval),
        .ACCEL_FILTER_ON(afon), .ACCEL_LOWPASS_SETTING(alpf),
        .ACCEL_RATE_KHZ(arate), .ACCEL_AVERAGES(avgs),
        .ACCEL_POWER_ON(pwr), .SAMPLE_STROBE(stb));

    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp,
                           input string what);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        n_tests++;
        if (got != exp)
        begin
            errors++;
            $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic wait_strobe(output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while (stb !== 1'b1 && k < 200);
    endtask

    // first strobe only syncs, since the divider count is mid-way
    task automatic interval(output int k);
        int m;
        wait_strobe(m);
        wait_strobe(k);
    endtask

    task automatic on_time(output int k);
        int g;
        g = 0;
        while (!(stb === 1'b1 && pwr === 1'b0) && g < 200)
        begin
            @(negedge clk);
            g++;
        end
        k = 0;
        @(negedge clk);
        while (pwr === 1'b1 && k < 50)
        begin
            k++;
            @(negedge clk);
        end
    endtask

    task automatic t_gyro();
        for (int r = 0; r < 4; r++)
        begin
            host_u.write_reg(`GYRO_CFG_ADDR, {3'b000, 2'(r), 3'b000});
            chk_val(12'(grs), 12'(r), "gyro range");
            chk_val(dps, 12'h0FA << r, "gyro dps");
        end
        for (int k = 0; k < 3; k++)
        begin
            host_u.write_reg(`GYRO_CFG_ADDR, 8'h20 << k);
            chk_val(12'(gst), 12'(1 << k), "gyro selftest");
        end
        host_u.gyro_setting = 3'h3;
        for (int b = 0; b < 4; b++)
        begin
            host_u.write_reg(`GYRO_CFG_ADDR, 8'(b));
            chk_val(12'(gfon), 12'(b == 0), "gyro filter");
            chk_val(12'(gnar), 12'(b == 2), "gyro narrow");
            chk_val(12'(grate), (b != 0) ? 12'h020 : 12'h001, "rate");
        end
        host_u.write_reg(`GYRO_CFG_ADDR, 8'h00);
        host_u.gyro_setting = 3'h7;
        repeat (2) @(negedge clk);
        chk_val(12'(grate), 12'h008, "grate setting 7");
        host_u.gyro_setting = 3'h0;
        repeat (2) @(negedge clk);
        chk_val(12'(grate), 12'h008, "grate setting 0");
        host_u.write_reg(`GYRO_CFG_ADDR, 8'hFF);
        host_u.read_reg(`GYRO_CFG_ADDR, d);
        chk_val(12'(d), 12'h0FB, "gyro readback");
        chk_val(12'(gst), 12'h007, "gyro selftest all");
        $display("test gyro done");
    endtask

    task automatic t_accel();
        for (int r = 0; r < 4; r++)
        begin
            host_u.write_reg(`ACCEL_CFG_ADDR, {3'b000, 2'(r), 3'b000});
            chk_val(12'(ars), 12'(r), "accel range");
            chk_val(12'(gval), 12'(5'h02 << r), "accel g");
        end
        for (int k = 0; k < 3; k++)
        begin
            host_u.write_reg(`ACCEL_CFG_ADDR, 8'h20 << k);
            chk_val(12'(ast), 12'(1 << k), "accel selftest");
        end
        host_u.write_reg(`ACCEL_CFG_ADDR, 8'hFF);
        host_u.read_reg(`ACCEL_CFG_ADDR, d);
        chk_val(12'(d), 12'h0F8, "accel readback");
        for (int s = 0; s < 8; s++)
        begin
            host_u.write_reg(`ACCEL_CFG2_ADDR, 8'(s));
            chk_val(12'(alpf), 12'(s), "accel lowpass");
            chk_val(12'(arate), 12'h001, "arate filtered");
        end
        for (int a = 0; a < 4; a++)
        begin
            host_u.write_reg(`ACCEL_CFG2_ADDR, {2'b00, 2'(a), 4'h7});
            chk_val(12'(avgs), 12'(6'h04 << a), "averages");
            chk_val(12'(afon), 12'h001, "accel filter on");
        end
        host_u.write_reg(`ACCEL_CFG2_ADDR, 8'hFF);
        chk_val(12'(afon), 12'h000, "accel bypass");
        chk_val(12'(arate), 12'h004, "arate bypass");
        chk_val(12'(avgs), 12'h001, "averages bypass");
        host_u.read_reg(`ACCEL_CFG2_ADDR, d);
        chk_val(12'(d), 12'h03F, "accel2 readback");
        host_u.write_reg(8'h1E, 8'hFF);
        host_u.read_reg(8'h1E, d);
        chk_val(12'(d), 12'h000, "unmapped read");
        host_u.read_reg(`GYRO_CFG_ADDR, d);
        chk_val(12'(d), 12'h0FB, "gyro untouched");
        $display("test accel done");
    endtask

    task automatic t_pacing();
        host_u.write_reg(`GYRO_CFG_ADDR, 8'h00);
        host_u.gyro_setting = 3'h3;
        host_u.divider = 8'h02;
        interval(n);
        chk_cnt(n, TICK * 3, "divided interval");
        host_u.gyro_setting = 3'h7;
        interval(n);
        chk_cnt(n, TICK, "setting 7 interval");
        host_u.gyro_setting = 3'h3;
        host_u.write_reg(`GYRO_CFG_ADDR, 8'h01);
        interval(n);
        chk_cnt(n, TICK, "bypass interval");
        host_u.write_reg(`GYRO_CFG_ADDR, 8'h00);
        host_u.divider = 8'h04;
        host_u.lowpower = 1'b1;
        host_u.set_lowpower(2'b00, 1'b1);
        on_time(n);
        chk_cnt(n, TON1, "on time single");
        for (int a = 0; a < 4; a++)
        begin
            host_u.set_lowpower(2'(a), 1'b0);
            on_time(n);
            chk_cnt(n, TONS[a], "on time averaged");
        end
        host_u.lowpower = 1'b0;
        repeat (2) @(negedge clk);
        chk_val(12'(pwr), 12'h001, "power outside low-power");
        $display("test pacing done");
    endtask

    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            wrap_up();
        end
    end

    initial
    begin
        errors = 0;
        n_tests = 0;
        cycles = 0;
        reset = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        host_u.read_reg(`GYRO_CFG_ADDR, d);
        chk_val(12'(d), 12'h000, "gyro reset");
        chk_val(dps, 12'h0FA, "dps reset");
        chk_val(12'(gval), 12'h002, "g reset");
        chk_val(12'(avgs), 12'h004, "averages reset");
        chk_val(12'(gfon), 12'h001, "gyro filter reset");
        chk_val(12'(afon), 12'h001, "accel filter reset");
        $display("test reset done");
        t_gyro();
        t_accel();
        t_pacing();
        wrap_up();
    end
endmodule
